// file: core/dds_pkg.sv
// Package with offsets, field positions, reset values and timing for the pin function block.
package dds_pkg;
   // Register offset of the pin configuration word.
   localparam logic [15:0] CFG_ADDR = 16'h0012;
   // Field positions for pin one.
   localparam int P1_SLEW_BIT = 15;
   localparam int P1_PEN_BIT = 14;
   localparam int P1_PTYPE_BIT = 13;
   localparam int P1_FN_LSB = 9;
   localparam int P1_VAL_BIT = 8;
   // Field positions for pin zero.
   localparam int P0_SLEW_BIT = 7;
   localparam int P0_PEN_BIT = 6;
   localparam int P0_PTYPE_BIT = 5;
   localparam int P0_FN_LSB = 1;
   localparam int P0_VAL_BIT = 0;
   // Reset value: both pulls on, pin one pulls up, pin zero pulls down.
   localparam logic [15:0] CFG_RESET = 16'h4060;
   // Pin function codes.
   localparam logic [3:0] FN_OFF = 4'h0;
   localparam logic [3:0] FN_GPIO = 4'h1;
   localparam logic [3:0] FN_SFD_TX = 4'h2;
   localparam logic [3:0] FN_SFD_RX = 4'h3;
   localparam logic [3:0] FN_LED_LINK = 4'h4;
   localparam logic [3:0] FN_LED_PLCA = 4'h5;
   localparam logic [3:0] FN_LED_TX = 4'h6;
   localparam logic [3:0] FN_LED_RX = 4'h7;
   localparam logic [3:0] FN_CLK = 4'h8;
   localparam logic [3:0] FN_SFD_ANY = 4'hB;
   localparam logic [3:0] FN_LED_ANY = 4'hF;
   // Timing: clock period, pulse length and LED stretch time.
   localparam int CLK_PERIOD_NS = 40;
   localparam int SFD_PULSE_NS = 200;
   localparam int SFD_PULSE_CYC = (SFD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LED_STRETCH_MS = 50;
   localparam int LED_STRETCH_CYC = (LED_STRETCH_MS * 1000000) / CLK_PERIOD_NS;
   localparam int LED_CNT_W = 21;
endpackage

// file: core/dds_dio_select.sv
// Function selection and output logic for the two auxiliary digital pins.
// Notes on behaviour
// - Slew bit per pin: one slow, zero fast.
// - Pull enable attaches pull; type one pulls down.
// - Four-bit function selector per pin.
// - Value bit drives GPIO, is unused in clock mode, else sets polarity.
// - Code 0x0 leaves the pin undriven.
// - Code 0x1 drives the value bit.
// - Code 0x2 pulses on transmitted SFD.
// - Code 0x3 pulses on received SFD.
// - Receive pulse and receive LED include transmit.
// - Code 0x4 lights LED when enabled and linked.
// - Code 0x5 lights LED when PLCA up.
// - Codes 0x6, 0x7 are transmit, receive activity LEDs.
// - Code 0xB pulses on either SFD.
// - Code 0xF shows combined activity LED.
// - Reset: pulls on, pin one up, pin zero down.
`timescale 1ns/1ps
`default_nettype none
module dds_dio_select #(
   parameter int LED_STRETCH = dds_pkg::LED_STRETCH_CYC
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Register port of the configuration word.
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   // Device status and frame events.
   input wire logic i_port_en,
   input wire logic i_link_up,
   input wire logic i_plca_up,
   input wire logic i_sfd_tx,
   input wire logic i_sfd_rx,
   input wire logic i_tx_act,
   input wire logic i_rx_act,
   input wire logic i_clk25,
   // Pin one drive, enable (low drives), slew and pull controls.
   output logic o_aux_pin_one,
   output logic o_aux_pin_one_oe_n,
   output logic o_aux_pin_one_slow,
   output logic o_aux_pin_one_pull_en,
   output logic o_aux_pin_one_pull_dn,
   // Pin zero drive, enable (low drives), slew and pull controls.
   output logic o_aux_pin_zero,
   output logic o_aux_pin_zero_oe_n,
   output logic o_aux_pin_zero_slow,
   output logic o_aux_pin_zero_pull_en,
   output logic o_aux_pin_zero_pull_dn
);

   logic [15:0] cfg_r, cfg_nxt, rdata_r, rdata_nxt;
   logic [2:0] ptx_r, ptx_nxt, prx_r, prx_nxt, pany_r, pany_nxt;
   logic [dds_pkg::LED_CNT_W-1:0] ltx_r, ltx_nxt, lrx_r, lrx_nxt;
   logic [1:0] pin_r, pin_nxt, oen_r, oen_nxt;
   logic [1:0] clk_sel_r, clk_sel_nxt;
   logic [1:0] slow_r, slow_nxt, pen_r, pen_nxt, pdn_r, pdn_nxt;
   logic tx_pulse, rx_pulse, any_pulse, tx_led, rx_led;

   // Pulse counter reload; returns the count minus one while busy.
   function automatic logic [2:0] pulse_next(input logic trig, input logic [2:0] cnt);
      if (trig) begin
         pulse_next = 3'(dds_pkg::SFD_PULSE_CYC);
      end else if (cnt != 3'h0) begin
         pulse_next = cnt - 3'h1;
      end else begin
         pulse_next = 3'h0;
      end
   endfunction

   // Activity stretcher; any activity restarts the hold time.
   function automatic logic [dds_pkg::LED_CNT_W-1:0] led_next(input logic act,
         input logic [dds_pkg::LED_CNT_W-1:0] cnt);
      if (act) begin
         led_next = dds_pkg::LED_CNT_W'(LED_STRETCH);
      end else if (cnt != '0) begin
         led_next = cnt - 1'b1;
      end else begin
         led_next = '0;
      end
   endfunction

   // True when a selector picks the reference clock, which bypasses the pin register.
   function automatic logic is_clk(input logic [3:0] fn);
      is_clk = fn == dds_pkg::FN_CLK;
   endfunction

   // Drive enable and level of one pin for its selected function, after polarity.
   function automatic logic [1:0] pin_drive(input logic [3:0] fn, input logic val,
         input logic [4:0] ev);
      logic lvl;
      logic drv;
      lvl = 1'b0;
      drv = 1'b1;
      case (fn)
         dds_pkg::FN_OFF: drv = 1'b0;
         dds_pkg::FN_GPIO: lvl = val;
         dds_pkg::FN_SFD_TX: lvl = ev[0];
         dds_pkg::FN_SFD_RX: lvl = ev[1];
         dds_pkg::FN_LED_LINK: lvl = i_port_en & i_link_up;
         dds_pkg::FN_LED_PLCA: lvl = i_plca_up;
         dds_pkg::FN_LED_TX: lvl = ev[2];
         dds_pkg::FN_LED_RX: lvl = ev[3];
         dds_pkg::FN_CLK: lvl = i_clk25;
         dds_pkg::FN_SFD_ANY: lvl = ev[1];
         dds_pkg::FN_LED_ANY: lvl = ev[4];
         default: drv = 1'b0; // Reserved codes stay undriven as a safe answer.
      endcase
      // Value bit is polarity in every mode but plain output and clock: zero inverts.
      if (fn != dds_pkg::FN_GPIO && !is_clk(fn) && !val) begin
         lvl = ~lvl;
      end
      pin_drive = {drv, lvl};
   endfunction

   // Configuration write and readback; unmapped addresses read as zero.
   always_comb begin
      cfg_nxt = cfg_r;
      if (i_reg_wr && i_reg_addr == dds_pkg::CFG_ADDR) begin
         cfg_nxt = i_reg_wdata;
      end
      // Readback takes the word after this edge, so a write reads back at once.
      rdata_nxt = 16'h0000;
      if (i_reg_addr == dds_pkg::CFG_ADDR) begin
         rdata_nxt = cfg_nxt;
      end
   end

   // Pulse shapers and activity stretchers; the rx pulse also counts tx.
   always_comb begin
      ptx_nxt = pulse_next(i_sfd_tx, ptx_r);
      prx_nxt = pulse_next(i_sfd_rx | i_sfd_tx, prx_r);
      pany_nxt = pulse_next(i_sfd_rx | i_sfd_tx, pany_r);
      ltx_nxt = led_next(i_tx_act, ltx_r);
      lrx_nxt = led_next(i_rx_act | i_tx_act, lrx_r);
   end

   // A counter or stretcher shows activity for as long as it is nonzero.
   assign tx_pulse = ptx_r != 3'h0;
   assign rx_pulse = prx_r != 3'h0;
   assign any_pulse = pany_r != 3'h0;
   assign tx_led = ltx_r != '0;
   assign rx_led = lrx_r != '0;

   // Pin outputs, registered once so a write shows two edges later.
   always_comb begin
      logic [1:0] d1;
      logic [1:0] d0;
      d1 = pin_drive(cfg_r[dds_pkg::P1_FN_LSB +: 4], cfg_r[dds_pkg::P1_VAL_BIT],
            {tx_led | rx_led, rx_led, tx_led, rx_pulse | any_pulse, tx_pulse});
      d0 = pin_drive(cfg_r[dds_pkg::P0_FN_LSB +: 4], cfg_r[dds_pkg::P0_VAL_BIT],
            {tx_led | rx_led, rx_led, tx_led, rx_pulse | any_pulse, tx_pulse});
      pin_nxt = {d1[0], d0[0]};
      oen_nxt = {~d1[1], ~d0[1]};
      slow_nxt = {cfg_r[dds_pkg::P1_SLEW_BIT], cfg_r[dds_pkg::P0_SLEW_BIT]};
      pen_nxt = {cfg_r[dds_pkg::P1_PEN_BIT], cfg_r[dds_pkg::P0_PEN_BIT]};
      pdn_nxt = {cfg_r[dds_pkg::P1_PTYPE_BIT], cfg_r[dds_pkg::P0_PTYPE_BIT]};
      clk_sel_nxt[1] = is_clk(cfg_r[dds_pkg::P1_FN_LSB +: 4]);
      clk_sel_nxt[0] = is_clk(cfg_r[dds_pkg::P0_FN_LSB +: 4]);
   end

   // Configuration group; the reset word turns both pulls on.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_r <= dds_pkg::CFG_RESET;
         rdata_r <= dds_pkg::CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Event group: pulse counters and activity stretchers start idle.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ptx_r <= 3'h0;
         prx_r <= 3'h0;
         pany_r <= 3'h0;
         ltx_r <= '0;
         lrx_r <= '0;
      end else begin
         ptx_r <= ptx_nxt;
         prx_r <= prx_nxt;
         pany_r <= pany_nxt;
         ltx_r <= ltx_nxt;
         lrx_r <= lrx_nxt;
      end
   end

   // Pin group; reset pulls match the configuration reset value.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_r <= 2'h0;
         oen_r <= 2'h3;
         slow_r <= 2'h0;
         pen_r <= 2'h3;
         pdn_r <= 2'h1;
         clk_sel_r <= 2'h0;
      end else begin
         pin_r <= pin_nxt;
         oen_r <= oen_nxt;
         slow_r <= slow_nxt;
         pen_r <= pen_nxt;
         pdn_r <= pdn_nxt;
         clk_sel_r <= clk_sel_nxt;
      end
   end

   // Readback and pin controls come straight from the registers above.
   assign o_reg_rdata = rdata_r;
   // In clock mode the pin takes the reference clock itself: a register on a clock of the
   // same rate could only hold a sampled level. The select is registered, so it cannot glitch
   // on a write, but the pin level in this one mode does not come from a flip-flop.
   assign o_aux_pin_one = clk_sel_r[1] ? i_clk25 : pin_r[1];
   assign o_aux_pin_zero = clk_sel_r[0] ? i_clk25 : pin_r[0];
   assign o_aux_pin_one_oe_n = oen_r[1];
   assign o_aux_pin_zero_oe_n = oen_r[0];
   assign o_aux_pin_one_slow = slow_r[1];
   assign o_aux_pin_zero_slow = slow_r[0];
   assign o_aux_pin_one_pull_en = pen_r[1];
   assign o_aux_pin_zero_pull_en = pen_r[0];
   assign o_aux_pin_one_pull_dn = pdn_r[1];
   assign o_aux_pin_zero_pull_dn = pdn_r[0];

endmodule
`default_nettype wire

// file: verification/dds_pin_watch.sv
// Model of the circuit outside one auxiliary pin: it resolves the wire level.
`timescale 1ns/1ps
`default_nettype none
module dds_pin_watch (
   // Clock and pin controls from the device.
   input wire logic i_clk,
   input wire logic i_pin,
   input wire logic i_oe_n,
   input wire logic i_pull_en,
   input wire logic i_pull_dn,
   // Level seen by the LED or logic on the pin.
   output logic o_level
);
   logic float_r = 1'b0;
   // A floating pin changes every cycle so it can never pass for a stable level.
   always @(posedge i_clk) float_r <= !float_r;
   // Driver wins, else the pull, else the floating pattern.
   assign o_level = !i_oe_n ? i_pin : i_pull_en ? !i_pull_dn : float_r;
endmodule
`default_nettype wire

// file: verification/dds_dio_select_props.sv
// Concurrent checks on the pin function block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dds_dio_select_props (
   // Clock, reset and register port.
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   // Frame event and pin controls.
   input wire logic i_sfd_tx,
   input wire logic o_aux_pin_zero,
   input wire logic o_aux_pin_zero_oe_n,
   input wire logic o_aux_pin_zero_slow,
   input wire logic o_aux_pin_one_pull_en,
   input wire logic o_aux_pin_one_pull_dn
);
   logic sel;
   logic hit;
   logic [15:0] cfg_r;
   // Shadow of the word, so modes are judged from the ports alone.
   assign sel = i_reg_addr == dds_pkg::CFG_ADDR;
   assign hit = i_reg_wr && sel;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) cfg_r <= dds_pkg::CFG_RESET;
      else if (hit) cfg_r <= i_reg_wdata;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // Pins follow the shadow one cycle late.
   property p_rd; hit ##1 (sel && !i_reg_wr) |=> o_reg_rdata == $past(i_reg_wdata, 2); endproperty
   a_rd: assert property (p_rd) else $error("readback differs");
   property p_unmapped; !sel |=> o_reg_rdata == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_slew; o_aux_pin_zero_slow == $past(cfg_r[7]); endproperty
   a_slew: assert property (p_slew) else $error("slew wrong");
   property p_pull; {o_aux_pin_one_pull_en, o_aux_pin_one_pull_dn} == $past(cfg_r[14:13]); endproperty
   a_pull: assert property (p_pull) else $error("pull wrong");
   property p_hiz; $past(cfg_r[4:1]) == dds_pkg::FN_OFF |-> o_aux_pin_zero_oe_n; endproperty
   a_hiz: assert property (p_hiz) else $error("pin driven");
   property p_gpio; $past(cfg_r[4:1]) == dds_pkg::FN_GPIO
      |-> !o_aux_pin_zero_oe_n && o_aux_pin_zero == $past(cfg_r[0]); endproperty
   a_gpio: assert property (p_gpio) else $error("output level wrong");
   sequence s_tx; i_sfd_tx && !i_reg_wr && cfg_r[4:0] == {dds_pkg::FN_SFD_TX, 1'b1}; endsequence
   property p_sfd; s_tx ##1 (!i_sfd_tx && !i_reg_wr)[*6]
      |=> !o_aux_pin_zero && $past(o_aux_pin_zero, 5); endproperty
   a_sfd: assert property (p_sfd) else $error("pulse length wrong");
   property p_rxtx; i_sfd_tx && !i_reg_wr && cfg_r[4:0] == {dds_pkg::FN_SFD_RX, 1'b1}
      ##1 !i_reg_wr |=> o_aux_pin_zero; endproperty
   a_rxtx: assert property (p_rxtx) else $error("no pulse on transmit");
   c_sfd: cover property (s_tx);
   c_gpio: cover property (hit && i_reg_wdata[4:1] == dds_pkg::FN_GPIO);
   c_unmapped: cover property (i_reg_wr && !sel);
endmodule
bind dds_dio_select dds_dio_select_props u_props (.i_sys_clk, .i_nrst, .i_reg_wr, .i_reg_addr,
   .i_reg_wdata, .o_reg_rdata, .i_sfd_tx, .o_aux_pin_zero, .o_aux_pin_zero_oe_n,
   .o_aux_pin_zero_slow, .o_aux_pin_one_pull_en, .o_aux_pin_one_pull_dn);
`default_nettype wire

// file: verification/dual_dio_function_select_tb.sv
// Self-checking bench for the auxiliary pin function block.
`timescale 1ns/1ps
`default_nettype none
module dual_dio_function_select_tb;
   logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, lvl0, lvl1;
   logic [15:0] i_reg_addr = dds_pkg::CFG_ADDR, i_reg_wdata = 16'h0000, o_reg_rdata;
   logic i_port_en = 1'b1, i_link_up = 1'b1, i_plca_up = 1'b1, i_clk25 = 1'b0;
   logic i_sfd_tx = 1'b0, i_sfd_rx = 1'b0, i_tx_act = 1'b0, i_rx_act = 1'b0;
   logic o_aux_pin_one, o_aux_pin_one_oe_n, o_aux_pin_one_slow;
   logic o_aux_pin_one_pull_en, o_aux_pin_one_pull_dn;
   logic o_aux_pin_zero, o_aux_pin_zero_oe_n, o_aux_pin_zero_slow;
   logic o_aux_pin_zero_pull_en, o_aux_pin_zero_pull_dn;
   int miscompares = 0, samples_checked = 0, n;
   logic [17:0] rows [12];
   logic [21:0] evs [10];
   // Clock at 25 MHz.
   always #20 i_sys_clk = !i_sys_clk;
   // Short LED stretch keeps the run brief.
   dds_dio_select #(.LED_STRETCH(20)) dut (.*);
   dds_pin_watch u_w0 (.i_clk(i_sys_clk), .i_pin(o_aux_pin_zero), .i_oe_n(o_aux_pin_zero_oe_n),
      .i_pull_en(o_aux_pin_zero_pull_en), .i_pull_dn(o_aux_pin_zero_pull_dn), .o_level(lvl0));
   dds_pin_watch u_w1 (.i_clk(i_sys_clk), .i_pin(o_aux_pin_one), .i_oe_n(o_aux_pin_one_oe_n),
      .i_pull_en(o_aux_pin_one_pull_en), .i_pull_dn(o_aux_pin_one_pull_dn), .o_level(lvl1));
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge i_sys_clk);
      {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
      @(negedge i_sys_clk);
      {i_reg_wr, i_reg_addr} = {1'b0, dds_pkg::CFG_ADDR};
      repeat (3) @(negedge i_sys_clk);
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Rows hold expected pin one level, pin zero level, then the word written.
   // Reserved selector codes are never written.
   initial begin
      rows = '{{2'b11, 16'h4003}, {2'b10, 16'h4002},
         {2'b11, 16'h40C0}, {2'b00, 16'h60E0},
         {2'b11, 16'h0309}, {2'b00, 16'h020A},
         {2'b11, 16'h400C}, {2'b11, 16'h400E}, {2'b11, 16'h401E},
         {2'b11, 16'h4004}, {2'b11, 16'h4016}, {2'b10, 16'h4010}};
      // Class (none, pulse, stretch), event {rx act, tx act, rx sfd, tx sfd}, word.
      evs = '{{2'h1, 4'h1, 16'h0005}, {2'h0, 4'h2, 16'h0005},
         {2'h1, 4'h1, 16'h0007}, {2'h1, 4'h2, 16'h0007},
         {2'h1, 4'h2, 16'h0017}, {2'h1, 4'h1, 16'h0017},
         {2'h2, 4'h4, 16'h000D}, {2'h0, 4'h8, 16'h000D},
         {2'h2, 4'h4, 16'h000F}, {2'h2, 4'h8, 16'h001F}};
      repeat (8) @(negedge i_sys_clk);
      chk(o_reg_rdata === dds_pkg::CFG_RESET && {lvl1, lvl0} === 2'b10, "reset state");
      i_nrst = 1'b1;
      $display("reset test done");
      foreach (rows[k]) begin
         wr(dds_pkg::CFG_ADDR, rows[k][15:0]);
         chk({lvl1, lvl0, o_reg_rdata} === rows[k], "table row");
      end
      $display("table test done");
      wr(16'h0013, 16'hFFFF);
      i_reg_addr = 16'h0013;
      @(negedge i_sys_clk);
      chk(o_reg_rdata === 16'h0000, "unmapped read");
      i_reg_addr = dds_pkg::CFG_ADDR;
      @(negedge i_sys_clk);
      chk(o_reg_rdata === rows[11][15:0], "stray write stored");
      $display("unmapped test done");
      // Pin zero is still in clock mode: its level must follow the clock within a half cycle.
      i_clk25 = 1'b1;
      #5;
      chk(lvl0 === 1'b1, "clock out high");
      @(negedge i_sys_clk);
      i_clk25 = 1'b0;
      #5;
      chk(lvl0 === 1'b0, "clock out low");
      $display("clock test done");
      // Count high cycles of a one-cycle event, active-high polarity.
      foreach (evs[k]) begin
         wr(dds_pkg::CFG_ADDR, evs[k][15:0]);
         {i_rx_act, i_tx_act, i_sfd_rx, i_sfd_tx} = evs[k][19:16];
         @(negedge i_sys_clk);
         {i_rx_act, i_tx_act, i_sfd_rx, i_sfd_tx} = 4'h0;
         n = 0;
         repeat (40) begin
            @(negedge i_sys_clk);
            n += (lvl0 === 1'b1);
         end
         chk(evs[k][21:20] == 2'h1 ? n == 5 : evs[k][21:20] == 2'h2 ? n >= 20 && n <= 22 : n == 0,
            "event length");
      end
      $display("event test done");
      // Both slew bits set, then a reset in mid-run must restore every pin control.
      wr(dds_pkg::CFG_ADDR, 16'h8083);
      chk({o_aux_pin_one_slow, o_aux_pin_zero_slow, lvl0} === 3'b111, "slew set");
      i_nrst = 1'b0;
      @(negedge i_sys_clk);
      chk({o_aux_pin_one_slow, o_aux_pin_zero_slow} === 2'b00, "slew reset");
      chk({o_aux_pin_one_oe_n, o_aux_pin_zero_oe_n} === 2'b11, "pins undriven");
      i_nrst = 1'b1;
      repeat (2) begin
         @(negedge i_sys_clk);
         chk(o_reg_rdata === dds_pkg::CFG_RESET && {lvl1, lvl0} === 2'b10, "release");
      end
      $display("mid-run reset test done");
      summarize();
   end
endmodule
`default_nettype wire
